// file: logic/etc_top.sv
// Purpose: per-bank error thresholding register with interrupt request
// Assumes: software reaches the register through a 64-bit access port
// Notes:   count and overflow survive the warm reset resetn
//
// Operation
// - bit 63 valid flag; present and block pointer fields then meaningful.
// - bit 62 reads one when the threshold counter is built.
// - locked bit 61 makes writes to bits 60:0 silently ignored.
// - lock bit itself writable only while lock_write_enable is set.
// - bit 60 read-only interrupt capability; kind field picks interrupt.
// - vector entry address is offset field shifted by four plus 500h.
// - errors counted only while count enable bit 51 is set.
// - kind field 00 none, 01 local interrupt, 10/11 reserved.
// - overflow flag sets when count steps FFFEh to FFFFh.
// - rising overflow raises the interrupt chosen by the kind field.
// - overflow and count kept across warm reset.
// - count in bits 47:32, unbuilt upper bits read zero.
// - count increments per logged error and saturates, never wraps.
// - block pointer bits 31:24; nonzero means further registers exist.
// - after reset all error-reporting enables are clear.
// - check condition with exception enable clear enters shutdown.
// - counter advances only for sources enabled for logging.
module etc_top
  import etc_pkg::*;
#(
  parameter int         CW          = COUNT_MAX_W,
  parameter logic [7:0] BLOCK_PTR   = 8'h00,
  parameter logic       IRQ_CAPABLE = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        resetn_cold,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic [63:0] reg_wdata,
  input  wire logic        lock_write_enable,
  input  wire logic        err_logged,
  input  wire logic        src_log_enable,
  input  wire logic        check_event,
  input  wire logic        check_exception_enable,
  output logic      [63:0] reg_rdata,
  output logic             irq_req,
  output logic      [11:0] vector_addr,
  output logic             machine_check,
  output logic             shutdown
);
  // ****************************************************************
  // control fields
  // ****************************************************************
  logic            os_lock_flag_q;
  logic [3:0]      vector_entry_offset_q;
  logic            count_enable_bit_q;
  logic [1:0]      irq_kind_field_q;
  logic            wr_ok;
  logic            inc;
  logic [CW-1:0]   cnt_q;
  logic            ovf_q;
  logic            ovf_prev_q;
  etc_state_t      state_q;
  etc_state_t      state_d;

  function automatic logic kind_is_local(input logic [1:0] k);
    return k == KIND_LOCAL;
  endfunction

  assign wr_ok = reg_wr && !os_lock_flag_q;
  assign inc   = err_logged && src_log_enable && count_enable_bit_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      os_lock_flag_q <= 1'b0;
    end else if (ce && reg_wr && lock_write_enable) begin
      os_lock_flag_q <= reg_wdata[LOCK_BIT];
    end
  end

  // enables cleared on warm reset resetn, so nothing counts until set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vector_entry_offset_q <= VOFF_RESET;
      count_enable_bit_q    <= 1'b0;
      irq_kind_field_q      <= KIND_RESET;
    end else if (ce && wr_ok) begin
      vector_entry_offset_q <= reg_wdata[VOFF_HI:VOFF_LO];
      count_enable_bit_q    <= reg_wdata[CNTEN_BIT];
      irq_kind_field_q      <= reg_wdata[KIND_HI:KIND_LO];
    end
  end

  // ****************************************************************
  // counter, cleared on cold reset only
  // ****************************************************************
  etc_count #(
    .CW (CW)
  ) u_count (
    .clk_sys     (clk_sys),
    .resetn_cold (resetn_cold),
    .ce          (ce),
    .inc         (inc),
    .load        (wr_ok),
    .load_cnt    (reg_wdata[COUNT_LO +: CW]),
    .load_ovf    (reg_wdata[OVF_BIT]),
    .cnt_q       (cnt_q),
    .ovf_q       (ovf_q)
  );

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn_cold) begin
    if (!resetn_cold) begin
      ovf_prev_q <= 1'b0;
    end else if (ce) begin
      ovf_prev_q <= ovf_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_req <= 1'b0;
    end else if (ce) begin
      irq_req <= IRQ_CAPABLE && ovf_q && !ovf_prev_q
                 && kind_is_local(irq_kind_field_q);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vector_addr <= VEC_BASE;
    end else if (ce) begin
      vector_addr <= VEC_BASE
                     + (12'(vector_entry_offset_q) << VEC_SHIFT);
    end
  end

  // ****************************************************************
  // register read image
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata                    <= '0;
      reg_rdata[VALID_BIT]         <= 1'b1;
      reg_rdata[PRESENT_BIT]       <= 1'b1;
      reg_rdata[LOCK_BIT]          <= os_lock_flag_q;
      reg_rdata[IRQCAP_BIT]        <= IRQ_CAPABLE;
      reg_rdata[VOFF_HI:VOFF_LO]   <= vector_entry_offset_q;
      reg_rdata[CNTEN_BIT]         <= count_enable_bit_q;
      reg_rdata[KIND_HI:KIND_LO]   <= irq_kind_field_q;
      reg_rdata[OVF_BIT]           <= ovf_q;
      reg_rdata[COUNT_LO +: CW]    <= cnt_q;
      reg_rdata[EXTRA_BLOCK_POINTER_HI:EXTRA_BLOCK_POINTER_LO]   <= BLOCK_PTR;
    end
  end

  // ****************************************************************
  // check exception / shutdown
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ETC_ST_OFF: begin
        if (check_event) begin
          state_d = ETC_ST_DOWN;
        end else if (check_exception_enable) begin
          state_d = ETC_ST_ARM;
        end
      end
      ETC_ST_ARM: begin
        if (!check_exception_enable) begin
          state_d = check_event ? ETC_ST_DOWN : ETC_ST_OFF;
        end
      end
      ETC_ST_DOWN: state_d = ETC_ST_DOWN;
      default:     state_d = ETC_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ETC_ST_OFF;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      machine_check <= 1'b0;
      shutdown      <= 1'b0;
    end else if (ce) begin
      machine_check <= check_event && state_q == ETC_ST_ARM
                       && check_exception_enable;
      shutdown      <= state_d == ETC_ST_DOWN;
    end
  end
endmodule : etc_top

// file: logic/etc_pkg.sv
// Purpose: constants for the error threshold counter register
// Assumes: 64-bit register reached through a plain register access port
// Notes:   field positions and reset values of the thresholding register
package etc_pkg;
  localparam int          VALID_BIT     = 63;
  localparam int          PRESENT_BIT   = 62;
  localparam int          LOCK_BIT      = 61;
  localparam int          IRQCAP_BIT    = 60;
  localparam int          VOFF_HI       = 55;
  localparam int          VOFF_LO       = 52;
  localparam int          CNTEN_BIT     = 51;
  localparam int          KIND_HI       = 50;
  localparam int          KIND_LO       = 49;
  localparam int          OVF_BIT       = 48;
  localparam int          COUNT_HI      = 47;
  localparam int          COUNT_LO      = 32;
  localparam int          EXTRA_BLOCK_POINTER_HI       = 31;
  localparam int          EXTRA_BLOCK_POINTER_LO       = 24;
  localparam int          COUNT_MAX_W   = 16;
  localparam logic [1:0]  KIND_NONE     = 2'h0;
  localparam logic [1:0]  KIND_LOCAL    = 2'h1;
  localparam logic [3:0]  VOFF_RESET    = 4'h0;
  localparam logic [1:0]  KIND_RESET    = 2'h0;
  localparam logic [11:0] VEC_BASE      = 12'h500;
  localparam int          VEC_SHIFT     = 4;

  typedef enum logic [2:0] {
    ETC_ST_OFF  = 3'h1,
    ETC_ST_ARM  = 3'h2,
    ETC_ST_DOWN = 3'h4
  } etc_state_t;
endpackage : etc_pkg

// file: logic/etc_count.sv
// Purpose: saturating error counter with overflow flag
// Assumes: warm reset does not reach this module
// Notes:   of the two resets only power-on reset clears count and flag; a write can clear them too
module etc_count
  import etc_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn_cold,
  input  wire logic          ce,
  input  wire logic          inc,
  input  wire logic          load,
  input  wire logic [CW-1:0] load_cnt,
  input  wire logic          load_ovf,
  output logic      [CW-1:0] cnt_q,
  output logic               ovf_q
);
  localparam logic [CW-1:0] CMAX = {CW{1'b1}};
  localparam logic [CW-1:0] CONE = {{(CW-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_sys or negedge resetn_cold) begin
    if (!resetn_cold) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (inc && cnt_q != CMAX) begin
        cnt_q <= cnt_q + CONE;
      end else if (load && !(inc && cnt_q != CMAX)) begin
        cnt_q <= load_cnt;
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn_cold) begin
    if (!resetn_cold) begin
      ovf_q <= 1'b0;
    end else if (ce) begin
      if (inc && cnt_q == CMAX - CONE) begin
        ovf_q <= 1'b1;
      end else if (load) begin
        ovf_q <= load_ovf;
      end
    end
  end
endmodule : etc_count

// file: tb/etc_top_assertions.sv
// Purpose: port checks of the error threshold register
// Assumes: reg_rdata and vector_addr lag field state by one edge
// Notes:   bound to every etc_top instance
module etc_top_assertions
  import etc_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        resetn_cold,
  input wire logic        ce,
  input wire logic        reg_wr,
  input wire logic [63:0] reg_wdata,
  input wire logic        lock_write_enable,
  input wire logic        err_logged,
  input wire logic        src_log_enable,
  input wire logic        check_event,
  input wire logic        check_exception_enable,
  input wire logic [63:0] reg_rdata,
  input wire logic        irq_req,
  input wire logic [11:0] vector_addr,
  input wire logic        machine_check,
  input wire logic        shutdown
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_irq_kind: assert property (
    irq_req |-> reg_rdata[60] && reg_rdata[50:49] == KIND_LOCAL)
    else $error("irq with wrong kind");
  a_irq_single: assert property (irq_req |=> !irq_req)
    else $error("irq pulse too long");
  a_irq_rise: assert property (irq_req |-> $rose(reg_rdata[48]))
    else $error("irq without overflow edge");
  a_vec_addr: assert property (
    vector_addr == VEC_BASE + {reg_rdata[55:52], 4'h0})
    else $error("vector address wrong");
  a_count_sat: assert property (
    reg_rdata[47:32] == 16'({CW{1'b1}}) && !$past(reg_wr)
    |=> reg_rdata[47:32] == 16'({CW{1'b1}}))
    else $error("count left maximum");
  a_lock_hold: assert property (
    reg_rdata[61] && $past(reg_wr) && !$past(lock_write_enable)
    |=> $stable(reg_rdata[55:49]))
    else $error("locked fields changed");
  a_lock_wen: assert property (
    !$past(reg_wr && lock_write_enable) |=> $stable(reg_rdata[61]))
    else $error("lock changed without enable");
  a_shut_enter: assert property (
    check_event && !check_exception_enable |=> shutdown)
    else $error("no shutdown");
  a_mc_armed: assert property (
    machine_check |-> $past(check_event) && $past(check_exception_enable, 2))
    else $error("check pulse not armed");
  a_count_idle: assert property (
    !(err_logged && src_log_enable) && !reg_wr
    |-> ##2 $stable(reg_rdata[47:32]))
    else $error("count moved without logged error");
endmodule // etc_top_assertions

bind etc_top etc_top_assertions #(.CW(CW)) etc_top_assertions_i (
  .clk_sys, .resetn, .resetn_cold, .ce, .reg_wr, .reg_wdata,
  .lock_write_enable, .err_logged, .src_log_enable, .check_event,
  .check_exception_enable, .reg_rdata, .irq_req, .vector_addr,
  .machine_check, .shutdown);

// file: tb/etc_top_tb_top.sv
// Purpose: directed register and counting tests of etc_top
// Assumes: inputs change at falling edges
// Notes:   block pointer set non-zero to see it in the image
module etc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import etc_pkg::*;
  // ************************************************************
  // stimulus and checks
  // ************************************************************
  localparam logic [63:0] RO = 64'hD000_0000_FF00_0000;
  logic        clk_sys = 1'h0, resetn = 1'h0, resetn_cold = 1'h0;
  logic        reg_wr = 1'h0, lock_write_enable = 1'h0, err_logged = 1'h0;
  logic        src_log_enable = 1'h0, check_event = 1'h0;
  logic        check_exception_enable = 1'h0;
  logic [63:0] reg_wdata = 64'h0, reg_rdata;
  logic        irq_req, machine_check, shutdown;
  logic [11:0] vector_addr;
  int          n_fail = 0, checks = 0;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end

  always #50 clk_sys = ~clk_sys;

  etc_top #(.BLOCK_PTR(8'h5A)) etc_top_i (
    .clk_sys, .resetn, .resetn_cold, .ce(1'h1), .reg_wr, .reg_wdata,
    .lock_write_enable, .err_logged, .src_log_enable, .check_event,
    .check_exception_enable, .reg_rdata, .irq_req, .vector_addr,
    .machine_check, .shutdown);

  function automatic logic [63:0] img(logic [3:0] o, logic e,
    logic [1:0] k, logic f, logic [15:0] c, logic l);
    return {2'h3, l, 1'h1, 4'h0, o, e, k, f, c, 8'h5A, 24'h0};
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(logic [63:0] d, logic l);
    reg_wdata = d;
    lock_write_enable = l;
    reg_wr = 1'h1;
    cyc(1);
    reg_wr = 1'h0;
    cyc(1);
  endtask

  task automatic hit();
    err_logged = 1'h1;
    cyc(1);
    err_logged = 1'h0;
    cyc(1);
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end

  initial begin
    cyc(12);
    resetn = 1'h1;
    resetn_cold = 1'h1;
    cyc(2);
    `CHK(reg_rdata, img(4'h0, 1'h0, 2'h0, 1'h0, 16'h0, 1'h0))
    `CHK(vector_addr, 12'h500)
    wr(img(4'hA, 1'h1, KIND_LOCAL, 1'h0, 16'hFFFD, 1'h0) ^ RO, 1'h0);
    `CHK(reg_rdata, img(4'hA, 1'h1, 2'h1, 1'h0, 16'hFFFD, 1'h0))
    `CHK(vector_addr, 12'h5A0)
    hit();
    `CHK(reg_rdata[47:32], 16'hFFFD)
    src_log_enable = 1'h1;
    hit();
    `CHK(reg_rdata[48:32], 17'h0FFFE)
    hit();
    `CHK(reg_rdata[48:32], 17'h1FFFF)
    `CHK(irq_req, 1'h1)
    cyc(1);
    `CHK(irq_req, 1'h0)
    hit();
    `CHK(reg_rdata[48:32], 17'h1FFFF)
    `CHK(irq_req, 1'h0)
    resetn = 1'h0;
    cyc(2);
    `CHK(reg_rdata, 64'h0)
    resetn = 1'h1;
    cyc(2);
    `CHK(reg_rdata, img(4'h0, 1'h0, 2'h0, 1'h1, 16'hFFFF, 1'h0))
    wr(img(4'h0, 1'h0, 2'h0, 1'h0, 16'hFFFE, 1'h0), 1'h0);
    hit();
    `CHK(reg_rdata[48:32], 17'h0FFFE)
    wr(img(4'h0, 1'h1, KIND_NONE, 1'h0, 16'hFFFE, 1'h0), 1'h0);
    hit();
    `CHK(reg_rdata[48:32], 17'h1FFFF)
    `CHK(irq_req, 1'h0)
    wr(img(4'h0, 1'h0, 2'h0, 1'h0, 16'h0, 1'h1), 1'h0);
    `CHK(reg_rdata[61], 1'h0)
    wr(img(4'h3, 1'h0, 2'h0, 1'h0, 16'h10, 1'h1), 1'h1);
    `CHK(reg_rdata, img(4'h3, 1'h0, 2'h0, 1'h0, 16'h10, 1'h1))
    wr(img(4'h7, 1'h1, 2'h1, 1'h0, 16'h20, 1'h1), 1'h0);
    `CHK(reg_rdata, img(4'h3, 1'h0, 2'h0, 1'h0, 16'h10, 1'h1))
    check_event = 1'h1;
    cyc(1);
    check_event = 1'h0;
    `CHK(shutdown, 1'h1)
    `CHK(machine_check, 1'h0)
    resetn = 1'h0;
    cyc(1);
    resetn = 1'h1;
    check_exception_enable = 1'h1;
    cyc(2);
    check_event = 1'h1;
    cyc(1);
    check_event = 1'h0;
    `CHK(machine_check, 1'h1)
    `CHK(shutdown, 1'h0)
    give_verdict();
  end
endmodule // etc_top_tb_top
